// file: hw/wkt_wakeup_timer.sv
// wake-up timer: 16-bit down counter on a divided oscillator clock
// assumes the oscillator and card-detect result arrive as async pins;
// trimming, card detection and power control live outside the block
`timescale 1ns/100ps
`default_nettype none
module wkt_wakeup_timer
  import wkt_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // avalon-mm slave
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // low-frequency oscillator, async pin
  input wire logic i_low_freq_oscillator,
  // card detect results, async pins, one level each
  input wire logic i_card_detect_done,
  input wire logic i_card_found,
  // system control enables
  input wire logic i_stay_active_en,
  input wire logic i_power_down_en,
  // events to the rest of the chip
  output logic o_wake_request,
  output logic o_osc_trim_start,
  output logic o_low_power_card_detect_start,
  output logic o_field_timer_select,
  output logic o_power_down,
  output logic o_stay_active,
  output logic o_irq
);
  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] osc_sync; // oscillator synchroniser
    logic osc_prev; // last synchronised oscillator level
    logic [1:0] done_sync; // detect-done synchroniser
    logic done_prev; // edge detect of done
    logic [1:0] found_sync; // found synchroniser
    logic [4:0] prescale; // divider count
    logic [7:0] control; // bits 5..0 stored, 7 running
    logic [7:0] reload_hi; // wake_reload_high_byte
    logic [7:0] reload_lo; // wake_reload_low_byte
    logic [15:0] count; // live counter
    wkt_state_e state; // idle, counting, detecting
    logic [1:0] irq_status; // sticky events
    logic [1:0] irq_mask; // enables
    logic ack; // bus answer
    logic waitreq; // registered waitrequest, high while idle
    logic [31:0] rdata; // bus read data
    logic wake; // wake pulse
    logic trim; // trim pulse
    logic detect; // detect start pulse
    logic field_sel; // field timer select during detect
    logic pdown; // power-down pulse
    logic stay; // stay active level
    logic irq; // interrupt level
  } wkt_reg_s;

  wkt_reg_s r;
  wkt_reg_s next_r;

  // read of register index, byte enables ignored
  function automatic logic [7:0] wkt_rd(input wkt_reg_s s, input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == WKT_IDX_CONTROL)
      v = {s.state != WKT_IDLE, 1'b0, s.control[5:0]}; // RULE_02 RULE_19
    else if (idx == WKT_IDX_RELOAD_HI)
      v = s.reload_hi;
    else if (idx == WKT_IDX_RELOAD_LO)
      v = s.reload_lo;
    else if (idx == WKT_IDX_COUNT_HI)
      v = s.count[15:8]; // RULE_18
    else if (idx == WKT_IDX_COUNT_LO)
      v = s.count[7:0]; // RULE_18
    else if (idx == WKT_IDX_IRQ_STATUS)
      v = {6'h00, s.irq_status};
    else if (idx == WKT_IDX_IRQ_MASK)
      v = {6'h00, s.irq_mask};
    return v;
  endfunction

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  logic [7:0] idx; // word index of the access
  logic wr_hit; // accepted write with low byte lane
  logic tick; // divided counter clock
  logic osc_rise; // oscillator rising edge
  logic underflow; // counter passing zero
  logic done_rise; // card detect finished
  logic [1:0] events; // new interrupt events
  logic [15:0] reload_word; // wake_reload_word

  always_comb
  begin
    next_r = r;
    idx = i_avs_address[9:2];
    wr_hit = i_avs_write && !r.ack && i_avs_byteenable[0];
    reload_word = {r.reload_hi, r.reload_lo};
    // synchronisers, first stage read only by second
    next_r.osc_sync = {r.osc_sync[0], i_low_freq_oscillator};
    next_r.done_sync = {r.done_sync[0], i_card_detect_done};
    next_r.found_sync = {r.found_sync[0], i_card_found};
    next_r.osc_prev = r.osc_sync[1];
    next_r.done_prev = r.done_sync[1];
    osc_rise = r.osc_sync[1] && !r.osc_prev;
    done_rise = r.done_sync[1] && !r.done_prev;
    // prescaler picks one edge in 1, 8, 16 or 32
    tick = 1'b0;
    if (osc_rise)
    begin
      case (r.control[1:0]) // RULE_15
        2'b00: tick = 1'b1;
        2'b01: tick = (r.prescale[2:0] == WKT_DIV8_LAST[2:0]);
        2'b10: tick = (r.prescale[3:0] == WKT_DIV16_LAST[3:0]);
        default: tick = (r.prescale == WKT_DIV32_LAST);
      endcase
      next_r.prescale = r.prescale + 5'h01;
    end
    underflow = tick && (r.state == WKT_COUNT) && (r.count == 16'h0000);
    next_r.wake = 1'b0;
    next_r.trim = 1'b0;
    next_r.detect = 1'b0;
    next_r.pdown = 1'b0;
    events = 2'b00;
    // ---- counter and sequencer
    case (r.state)
      WKT_COUNT:
      begin
        if (underflow)
        begin
          events[WKT_IRQ_UNDERFLOW] = 1'b1; // RULE_12
          next_r.wake = r.control[WKT_BIT_WAKE]; // RULE_01 RULE_13
          next_r.trim = r.control[WKT_BIT_TRIM]; // RULE_04
          if (r.control[WKT_BIT_CARD])
          begin
            next_r.detect = 1'b1; // RULE_06
            next_r.field_sel = 1'b1; // RULE_10
            next_r.state = WKT_DETECT;
          end
          else if (r.control[WKT_BIT_RELOAD])
            next_r.count = reload_word; // RULE_11 RULE_16
          else
            next_r.state = WKT_IDLE; // RULE_11
        end
        else if (tick)
          next_r.count = r.count - 16'h0001; // RULE_17
      end
      WKT_DETECT:
      begin
        if (done_rise)
        begin
          next_r.field_sel = 1'b0;
          if (r.found_sync[1])
          begin
            events[WKT_IRQ_CARD] = 1'b1; // RULE_07
            next_r.stay = i_stay_active_en; // RULE_07
          end
          else
            next_r.pdown = i_power_down_en; // RULE_08
          next_r.count = reload_word; // RULE_09 RULE_16
          next_r.state = WKT_COUNT; // RULE_09
        end
      end
      default:
      begin
      end
    endcase
    // ---- bus access, one-cycle answer
    next_r.ack = (i_avs_read || i_avs_write) && !r.ack;
    // kept as its own flop so the pin needs no inverter after the register
    next_r.waitreq = !next_r.ack;
    if (i_avs_read && !r.ack)
      next_r.rdata = {24'h000000, wkt_rd(r, idx)};
    if (wr_hit)
    begin
      if (idx == WKT_IDX_CONTROL)
      begin
        next_r.control = {2'b00, i_avs_writedata[5:0]};
        if (i_avs_writedata[WKT_BIT_RUN_WE]) // RULE_03
        begin
          if (i_avs_writedata[WKT_BIT_RUNNING])
          begin
            next_r.state = WKT_COUNT;
            next_r.count = reload_word; // RULE_16
            next_r.prescale = 5'h00;
          end
          else
          begin
            next_r.state = WKT_IDLE;
            next_r.field_sel = 1'b0;
          end
        end
      end
      else if (idx == WKT_IDX_RELOAD_HI)
        next_r.reload_hi = i_avs_writedata[7:0]; // RULE_17
      else if (idx == WKT_IDX_RELOAD_LO)
        next_r.reload_lo = i_avs_writedata[7:0]; // RULE_17
      else if (idx == WKT_IDX_IRQ_STATUS)
        next_r.irq_status = r.irq_status & ~i_avs_writedata[1:0];
      else if (idx == WKT_IDX_IRQ_MASK)
        next_r.irq_mask = i_avs_writedata[1:0];
    end
    // set wins over a clear in the same cycle
    next_r.irq_status = next_r.irq_status | events;
    next_r.irq = |(next_r.irq_status & next_r.irq_mask);
    if (!i_rst_n)
    begin
      next_r = '0;
      next_r.control = WKT_RST_CONTROL;
      next_r.reload_hi = WKT_RST_RELOAD;
      next_r.reload_lo = WKT_RST_RELOAD;
      next_r.irq_status = WKT_RST_IRQ;
      next_r.irq_mask = WKT_RST_IRQ;
      next_r.state = WKT_IDLE;
      // bus shows busy while in reset
      next_r.waitreq = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // state register, reset folded into the next value
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    r <= next_r;
  end

  // outputs straight from flops
  assign o_avs_readdata = r.rdata;
  assign o_avs_waitrequest = r.waitreq;
  assign o_wake_request = r.wake;
  assign o_osc_trim_start = r.trim;
  assign o_low_power_card_detect_start = r.detect;
  assign o_field_timer_select = r.field_sel;
  assign o_power_down = r.pdown;
  assign o_stay_active = r.stay;
  assign o_irq = r.irq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  AST_RUN_BIT: assert property (o_avs_waitrequest == 1'b0 && $past(i_avs_read)
    && $past(i_avs_address[9:2]) == WKT_IDX_CONTROL && $past(r.state) == WKT_IDLE
    |-> o_avs_readdata[7] == 1'b0) else $error("running bit wrong"); // RULE_02
  AST_NO_WE: assert property (wr_hit && idx == WKT_IDX_CONTROL
    && !i_avs_writedata[WKT_BIT_RUN_WE] |=> r.state == $past(r.state) || $past(tick)
    || $past(done_rise)) else $error("run state changed without enable"); // RULE_03
  AST_TRIM: assert property (underflow |=> o_osc_trim_start == $past(r.control[5]))
    else $error("trim start mismatch"); // RULE_04
  AST_DETECT: assert property (underflow && r.control[4] |=> o_low_power_card_detect_start
    && o_field_timer_select) else $error("card detect not started"); // RULE_06
  AST_NOGAP: assert property (r.state == WKT_DETECT && done_rise && !wr_hit
    |=> r.state == WKT_COUNT && r.count == $past(reload_word)) else $error("restart gap"); // RULE_09
  AST_STOP: assert property (underflow && !r.control[4] && !r.control[3] && !wr_hit
    |=> r.state == WKT_IDLE) else $error("counter did not stop"); // RULE_11
  AST_IRQ_SET: assert property (underflow |=> r.irq_status[0])
    else $error("underflow flag not set"); // RULE_12
  AST_WAKE: assert property (underflow && r.control[2] |=> o_wake_request)
    else $error("no wake on underflow"); // RULE_13
  AST_HOLD: assert property (r.state == WKT_COUNT && !tick && !wr_hit |=> r.count == $past(r.count))
    else $error("counter moved without tick"); // RULE_17
  COV_UNDER: cover property (underflow);
  COV_CARD: cover property (done_rise && r.found_sync[1] && r.state == WKT_DETECT);
  COV_RELOAD: cover property (underflow && r.control[3] && !r.control[4]);
  // a detect that finds nothing, the power-down path
  COV_EMPTY: cover property (done_rise && !r.found_sync[1] && r.state == WKT_DETECT);

  // ---------------------------------------------------------------
  // further checks on events, reads and the interrupt level
  // ---------------------------------------------------------------
  // running bit reads one while the timer counts or detects
  AST_RUN_BIT_HI: assert property (o_avs_waitrequest == 1'b0 && $past(i_avs_read) // RULE_02
    && $past(i_avs_address[9:2]) == WKT_IDX_CONTROL && $past(r.state) != WKT_IDLE
    |-> o_avs_readdata[7] == 1'b1) else $error("running bit low while counting");
  // write-only enable never shows on a read
  AST_WE_ZERO: assert property (o_avs_waitrequest == 1'b0 && $past(i_avs_read) // RULE_19
    && $past(i_avs_address[9:2]) == WKT_IDX_CONTROL
    |-> o_avs_readdata[6] == 1'b0) else $error("write enable bit read back");
  // a start loads the whole reload word, not a stale half
  AST_START_LOAD: assert property (wr_hit && idx == WKT_IDX_CONTROL // RULE_16
    && i_avs_writedata[WKT_BIT_RUN_WE] && i_avs_writedata[WKT_BIT_RUNNING]
    |=> r.state == WKT_COUNT && r.count == $past(reload_word)) else $error("start did not load");
  // auto reload keeps counting from the reload word
  AST_RELOAD: assert property (underflow && !r.control[4] && r.control[3] && !wr_hit // RULE_11
    |=> r.state == WKT_COUNT && r.count == $past(reload_word)) else $error("no reload");
  // card found sets its sticky flag
  AST_CARD_IRQ: assert property (r.state == WKT_DETECT && done_rise && r.found_sync[1] // RULE_07
    |=> r.irq_status[1]) else $error("card flag not set");
  // empty field asks for power-down only when enabled
  AST_PDOWN: assert property (r.state == WKT_DETECT && done_rise && !r.found_sync[1] // RULE_08
    |=> o_power_down == $past(i_power_down_en)) else $error("power-down pulse wrong");
  // interrupt line follows the masked status one-for-one
  AST_IRQ_LEVEL: assert property (o_irq == |(r.irq_status & r.irq_mask)) // RULE_12
    else $error("interrupt level wrong");
  // an answer lasts exactly one cycle
  AST_WAIT_ONE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) // RULE_18
    else $error("waitrequest low too long");
endmodule : wkt_wakeup_timer
`default_nettype wire

// file: pkg/wkt_pkg.sv
// constants, register map and types for the wake-up timer block
// assumes a single 100 MHz clock domain and a 32-bit avalon-mm slave port
// Notes on behaviour
// RULE_01: underflow wakes system, optionally starts card detect
// RULE_02: control bit 7 shows timer running
// RULE_03: run state changes only with bit 6 set
// RULE_04: bit 5 launches oscillator trim on underflow
// RULE_05: software picks a legal trimming timer
// RULE_06: bit 4 launches card detect on underflow
// RULE_07: card found raises interrupt, may stay active
// RULE_08: no card enters power-down if enabled
// RULE_09: card detect end restarts timer without gap
// RULE_10: fourth timer times field-on during detect
// RULE_11: bit 3 reloads at zero, else stops
// RULE_12: underflow sets timer interrupt flag
// RULE_13: bit 2 wakes chip on every underflow
// RULE_14: software sets auto-wake for return to power-down
// RULE_15: clock field selects oscillator divide 1/8/16/32
// RULE_16: start loads counter from reload bytes
// RULE_17: reload writes wait for next start
// RULE_18: live counter readable as two bytes
// RULE_19: run-state write enable reads back zero
package wkt_pkg;
  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] WKT_IDX_CONTROL = 8'h23;
  localparam logic [7:0] WKT_IDX_RELOAD_HI = 8'h24;
  localparam logic [7:0] WKT_IDX_RELOAD_LO = 8'h25;
  localparam logic [7:0] WKT_IDX_COUNT_HI = 8'h26;
  localparam logic [7:0] WKT_IDX_COUNT_LO = 8'h27;
  localparam logic [7:0] WKT_IDX_IRQ_STATUS = 8'h28;
  localparam logic [7:0] WKT_IDX_IRQ_MASK = 8'h29;
  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int WKT_BIT_RUNNING = 7;
  localparam int WKT_BIT_RUN_WE = 6;
  localparam int WKT_BIT_TRIM = 5;
  localparam int WKT_BIT_CARD = 4;
  localparam int WKT_BIT_RELOAD = 3;
  localparam int WKT_BIT_WAKE = 2;
  // interrupt status bit positions
  localparam int WKT_IRQ_UNDERFLOW = 0;
  localparam int WKT_IRQ_CARD = 1;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] WKT_RST_CONTROL = 8'h00;
  localparam logic [7:0] WKT_RST_RELOAD = 8'h00;
  localparam logic [1:0] WKT_RST_IRQ = 2'h0;
  // divider terminal counts, prescaler counts edges of the oscillator
  localparam logic [4:0] WKT_DIV8_LAST = 5'h07;
  localparam logic [4:0] WKT_DIV16_LAST = 5'h0f;
  localparam logic [4:0] WKT_DIV32_LAST = 5'h1f;
  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {WKT_IDLE, WKT_COUNT, WKT_DETECT} wkt_state_e;
endpackage : wkt_pkg

// file: tb/tb.sv
// self-checking bench for the wake-up timer: registers, countdown, events
// assumes wkt_pkg compiled first; the bench makes the oscillator and detect pins
`timescale 1ns/100ps
`default_nettype none
module tb
  import wkt_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0; // held low for 8 cycles
  logic [9:0] i_avs_address = 10'h000;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'h1; // only byte 0 carries data
  logic i_osc = 1'b0; // oscillator stands low between ticks
  logic i_done = 1'b0;
  logic i_found = 1'b0;
  logic i_stay_en = 1'b1;
  logic i_pd_en = 1'b1;
  logic [31:0] o_rd;
  logic o_wait, o_wake, o_trim, o_card, o_field, o_pd, o_stay, o_irq;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_wake = 0; // pulse counters, one count per cycle high
  int n_trim = 0;
  int n_card = 0;
  int n_pd = 0;

  always #5 i_mclk = ~i_mclk;

  wkt_wakeup_timer DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_rd), .o_avs_waitrequest(o_wait),
    .i_low_freq_oscillator(i_osc), .i_card_detect_done(i_done), .i_card_found(i_found),
    .i_stay_active_en(i_stay_en), .i_power_down_en(i_pd_en), .o_wake_request(o_wake),
    .o_osc_trim_start(o_trim), .o_low_power_card_detect_start(o_card),
    .o_field_timer_select(o_field), .o_power_down(o_pd), .o_stay_active(o_stay), .o_irq(o_irq));

  // pulses last one cycle, so a clocked count sees each exactly once
  always @(posedge i_mclk)
  begin
    if (o_wake === 1'b1) n_wake++;
    if (o_trim === 1'b1) n_trim++;
    if (o_card === 1'b1) n_card++;
    if (o_pd === 1'b1) n_pd++;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one avalon cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    int k;
    i_avs_address <= {idx, 2'b00};
    i_avs_writedata <= {24'h0, wd};
    i_avs_write <= wr;
    i_avs_read <= ~wr;
    k = 0;
    do
    begin
      @(posedge i_mclk);
      k++;
    end while (o_wait !== 1'b0 && k < 50);
    rd = o_rd;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    if (k >= 50)
    begin
      n_mismatch++;
      complete_run();
    end
    @(posedge i_mclk); // a gap so no strobe is set twice in one step
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 8'h00, d);
    check(name, d, {24'h0, exp});
  endtask

  // oscillator rising edges, slow enough for the two-flop synchroniser
  task automatic ticks(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge i_mclk);
      i_osc <= 1'b1;
      repeat (4) @(posedge i_mclk);
      i_osc <= 1'b0;
    end
    repeat (8) @(posedge i_mclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_chk("control", WKT_IDX_CONTROL, WKT_RST_CONTROL);
    wr(WKT_IDX_RELOAD_HI, 8'h12);
    wr(WKT_IDX_RELOAD_LO, 8'h34);
    rd_chk("reload hi", WKT_IDX_RELOAD_HI, 8'h12);
    rd_chk("reload lo", WKT_IDX_RELOAD_LO, 8'h34);
    i_avs_byteenable <= 4'h0; // no low lane, write must be dropped
    wr(WKT_IDX_RELOAD_HI, 8'h55);
    i_avs_byteenable <= 4'h1;
    rd_chk("reload hi", WKT_IDX_RELOAD_HI, 8'h12);
    wr(WKT_IDX_COUNT_HI, 8'hff); // read-only, write dropped
    rd_chk("count hi", WKT_IDX_COUNT_HI, 8'h00);
    rd_chk("unmapped", 8'h30, 8'h00);
    wr(WKT_IDX_IRQ_MASK, 8'h01);
    $display("test regs done");
  endtask

  task automatic t_oneshot();
    wr(WKT_IDX_RELOAD_HI, 8'h00);
    wr(WKT_IDX_RELOAD_LO, 8'h03);
    wr(WKT_IDX_CONTROL, 8'h80); // run bit without write enable
    rd_chk("control", WKT_IDX_CONTROL, 8'h00);
    wr(WKT_IDX_CONTROL, 8'hc4);
    rd_chk("control", WKT_IDX_CONTROL, 8'h84);
    rd_chk("count lo", WKT_IDX_COUNT_LO, 8'h03);
    wr(WKT_IDX_RELOAD_LO, 8'h09); // must not touch the running count
    ticks(2);
    rd_chk("count lo", WKT_IDX_COUNT_LO, 8'h01);
    ticks(2); // 1 to 0, then underflow at zero
    rd_chk("count lo", WKT_IDX_COUNT_LO, 8'h00);
    rd_chk("control", WKT_IDX_CONTROL, 8'h04);
    rd_chk("status", WKT_IDX_IRQ_STATUS, 8'h01);
    check("irq", o_irq, 1);
    check("wake", n_wake, 1);
    wr(WKT_IDX_IRQ_STATUS, 8'h01);
    check("irq", o_irq, 0);
    $display("test oneshot done");
  endtask

  task automatic t_reload();
    wr(WKT_IDX_CONTROL, 8'hc8); // auto reload, wake off
    rd_chk("count lo", WKT_IDX_COUNT_LO, 8'h09);
    ticks(10);
    rd_chk("count lo", WKT_IDX_COUNT_LO, 8'h09);
    rd_chk("control", WKT_IDX_CONTROL, 8'h88);
    rd_chk("status", WKT_IDX_IRQ_STATUS, 8'h01);
    check("wake", n_wake, 1);
    wr(WKT_IDX_IRQ_STATUS, 8'h01);
    wr(WKT_IDX_CONTROL, 8'h89); // divide by 8, run state kept
    rd_chk("control", WKT_IDX_CONTROL, 8'h89);
    ticks(8); // any 8 edges hold exactly one divided tick
    rd_chk("count lo", WKT_IDX_COUNT_LO, 8'h08);
    wr(WKT_IDX_CONTROL, 8'h49);
    rd_chk("control", WKT_IDX_CONTROL, 8'h09);
    $display("test reload done");
  endtask

  task automatic t_detect();
    wr(WKT_IDX_RELOAD_LO, 8'h01);
    wr(WKT_IDX_CONTROL, 8'hf0); // trim and card detect, no wake
    ticks(2);
    check("trim", n_trim, 1);
    check("card start", n_card, 1);
    check("field", o_field, 1);
    i_done <= 1'b1;
    i_found <= 1'b1;
    repeat (8) @(posedge i_mclk);
    check("field", o_field, 0);
    check("stay", o_stay, 1);
    check("power down", n_pd, 0);
    rd_chk("status", WKT_IDX_IRQ_STATUS, 8'h03);
    rd_chk("control", WKT_IDX_CONTROL, 8'hb0);
    rd_chk("count lo", WKT_IDX_COUNT_LO, 8'h01);
    i_done <= 1'b0;
    i_found <= 1'b0;
    repeat (8) @(posedge i_mclk);
    wr(WKT_IDX_IRQ_STATUS, 8'h03);
    ticks(2);
    check("card start", n_card, 2);
    i_done <= 1'b1;
    repeat (8) @(posedge i_mclk);
    check("power down", n_pd, 1);
    rd_chk("status", WKT_IDX_IRQ_STATUS, 8'h01);
    check("wake", n_wake, 1);
    i_done <= 1'b0;
    repeat (8) @(posedge i_mclk);
    i_pd_en <= 1'b0; // empty field with power-down disabled
    ticks(2);
    check("card start", n_card, 3);
    i_done <= 1'b1;
    repeat (8) @(posedge i_mclk);
    check("power down", n_pd, 1);
    i_done <= 1'b0;
    i_pd_en <= 1'b1;
    $display("test detect done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    t_regs();
    t_oneshot();
    t_reload();
    t_detect();
    complete_run();
  end
endmodule // tb
`default_nettype wire
